// ===== logic/ecc_fault_injection_control.sv
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "ecc_inject_cfg.svh"
// How it works
// - Enable bit 0 of control register arms injection; clearing it stops all inversions.
// - Control register bits 15 to 1 read zero and ignore writes.
// - First pointer, low byte of pointer register, inverts code-word bit 0 to 55.
// - Pointer values 56 to 255 invert nothing at that pointer.
// - Second pointer, high byte, same coding, inverts one more bit unless it equals the first pointer.
module ecc_fault_injection_control
  import ecc_inject_pkg::*;
(
  input  wire logic         clk_sys,      // System clock, 125 MHz
  input  wire logic         reset_n,      // Asynchronous reset, active low
  input  wire reg_addr_type regAddr,      // Register address
  input  wire reg_word_type regWrData,    // Register write data
  input  wire logic         regWrStrobe,  // One-cycle write strobe
  input  wire logic         regRdStrobe,  // One-cycle read strobe
  output logic              [15:0] regRdData, // Read data, cycle after strobe
  input  wire codeword_type codeIn,       // Code word from encoder
  input  wire logic         codeInValid,  // Code word valid
  output codeword_type      codeOut,      // Code word with forced errors
  output logic              codeOutValid  // Output word valid
);

  logic         enable_q;
  logic         enable_d;
  pointer_type  firstPtr_q;
  pointer_type  firstPtr_d;
  pointer_type  secondPtr_q;
  pointer_type  secondPtr_d;
  reg_word_type rdData_q;
  reg_word_type rdData_d;
  codeword_type codeOut_q;
  codeword_type codeOut_d;
  logic         outValid_q;
  logic         outValid_d;

  flip_mask_if maskBus ();

  flip_mask_gen maskGen (
    .maskBus (maskBus.gen)
  );

  assign maskBus.injectEnable      = enable_q;
  assign maskBus.firstFlipPointer  = firstPtr_q;
  assign maskBus.secondFlipPointer = secondPtr_q;

  // Register file
  always_comb
  begin
    enable_d    = enable_q;
    firstPtr_d  = firstPtr_q;
    secondPtr_d = secondPtr_q;
    rdData_d    = '0;
    if (regWrStrobe)
    begin
      if (regAddr == `ADDR_ENABLE_CONTROL)
      begin
        enable_d = regWrData[`ENABLE_BIT];
      end
      else if (regAddr == `ADDR_BIT_POINTERS)
      begin
        firstPtr_d  = regWrData[`FIRST_PTR_LSB +: 8];
        secondPtr_d = regWrData[`SECOND_PTR_LSB +: 8];
      end
    end
    if (regRdStrobe)
    begin
      if (regAddr == `ADDR_ENABLE_CONTROL)
      begin
        rdData_d[`ENABLE_BIT] = enable_q;
      end
      else if (regAddr == `ADDR_BIT_POINTERS)
      begin
        rdData_d = {secondPtr_q, firstPtr_q};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      enable_q    <= 1'(`ENABLE_CONTROL_RESET >> `ENABLE_BIT);
      firstPtr_q  <= pointer_type'(`BIT_POINTERS_RESET >> `FIRST_PTR_LSB);
      secondPtr_q <= pointer_type'(`BIT_POINTERS_RESET >> `SECOND_PTR_LSB);
      rdData_q    <= '0;
    end
    else
    begin
      enable_q    <= enable_d;
      firstPtr_q  <= firstPtr_d;
      secondPtr_q <= secondPtr_d;
      rdData_q    <= rdData_d;
    end
  end

  assign regRdData = rdData_q;

  // Data path: one register stage so the mask never glitches into the output
  always_comb
  begin
    outValid_d = codeInValid;
    codeOut_d  = codeOut_q;
    if (codeInValid)
    begin
      codeOut_d = codeIn ^ maskBus.flipMask;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      codeOut_q  <= '0;
      outValid_q <= 1'b0;
    end
    else
    begin
      codeOut_q  <= codeOut_d;
      outValid_q <= outValid_d;
    end
  end

  assign codeOut      = codeOut_q;
  assign codeOutValid = outValid_q;

  // Checks; flipped bits are measured against the word sampled one edge earlier
  logic firstOk;
  logic secondOk;
  assign firstOk  = firstPtr_q < `POINTER_LIMIT;
  assign secondOk = secondPtr_q < `POINTER_LIMIT;

  property p_disabled_passthrough;
    @(posedge clk_sys) disable iff (!reset_n)
    codeInValid && !enable_q |=> codeOutValid && codeOut == $past(codeIn);
  endproperty
  a_disabled_passthrough: assert property (p_disabled_passthrough)
    else $error("Code word altered while injection disabled");

  property p_control_upper_zero;
    @(posedge clk_sys) disable iff (!reset_n)
    regRdStrobe && regAddr == `ADDR_ENABLE_CONTROL |=> regRdData[15:1] == 15'h0000;
  endproperty
  a_control_upper_zero: assert property (p_control_upper_zero)
    else $error("Unused control bits read nonzero");

  property p_first_single_flip;
    @(posedge clk_sys) disable iff (!reset_n)
    codeInValid && enable_q && firstOk && !secondOk
      |=> (codeOut ^ $past(codeIn)) == (56'h1 << $past(firstPtr_q));
  endproperty
  a_first_single_flip: assert property (p_first_single_flip)
    else $error("First pointer did not flip exactly its bit");

  property p_out_of_range_none;
    @(posedge clk_sys) disable iff (!reset_n)
    codeInValid && enable_q && !firstOk && !secondOk |=> (codeOut ^ $past(codeIn)) == 56'h0;
  endproperty
  a_out_of_range_none: assert property (p_out_of_range_none)
    else $error("Out-of-range pointers flipped a bit");

  property p_second_single_flip;
    @(posedge clk_sys) disable iff (!reset_n)
    codeInValid && enable_q && secondOk && !firstOk
      |=> (codeOut ^ $past(codeIn)) == (56'h1 << $past(secondPtr_q));
  endproperty
  a_second_single_flip: assert property (p_second_single_flip)
    else $error("Second pointer did not flip exactly its bit");

  property p_double_flip;
    @(posedge clk_sys) disable iff (!reset_n)
    codeInValid && enable_q && firstOk && secondOk && firstPtr_q != secondPtr_q
      |=> $countones(codeOut ^ $past(codeIn)) == 2;
  endproperty
  a_double_flip: assert property (p_double_flip)
    else $error("Two distinct pointers did not give a double-bit error");

  property p_pointer_readback;
    @(posedge clk_sys) disable iff (!reset_n)
    regWrStrobe && regAddr == `ADDR_BIT_POINTERS ##1 regRdStrobe && regAddr == `ADDR_BIT_POINTERS
      |=> regRdData == $past(regWrData, 2);
  endproperty
  a_pointer_readback: assert property (p_pointer_readback)
    else $error("Pointer register did not read back written value");

  // Equal pointers must not cancel each other out
  property p_equal_pointers_single;
    @(posedge clk_sys) disable iff (!reset_n)
    codeInValid && enable_q && firstOk && firstPtr_q == secondPtr_q
      |=> $countones(codeOut ^ $past(codeIn)) == 1;
  endproperty
  a_equal_pointers_single: assert property (p_equal_pointers_single)
    else $error("Equal pointers did not flip exactly one bit");

  property p_enable_write;
    @(posedge clk_sys) disable iff (!reset_n)
    regWrStrobe && regAddr == `ADDR_ENABLE_CONTROL |=> enable_q == $past(regWrData[`ENABLE_BIT]);
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("Enable bit did not follow the written value");

  property p_unmapped_read_zero;
    @(posedge clk_sys) disable iff (!reset_n)
    regRdStrobe && regAddr != `ADDR_ENABLE_CONTROL && regAddr != `ADDR_BIT_POINTERS
      |=> regRdData == 16'h0000;
  endproperty
  a_unmapped_read_zero: assert property (p_unmapped_read_zero)
    else $error("Unmapped address read nonzero");

  property p_read_idle_zero;
    @(posedge clk_sys) disable iff (!reset_n)
    !regRdStrobe |=> regRdData == 16'h0000;
  endproperty
  a_read_idle_zero: assert property (p_read_idle_zero)
    else $error("Read data nonzero without a read");

  property p_valid_follows;
    @(posedge clk_sys) disable iff (!reset_n)
    codeInValid |=> codeOutValid;
  endproperty
  a_valid_follows: assert property (p_valid_follows)
    else $error("Output valid missing after an input word");

  property p_idle_hold;
    @(posedge clk_sys) disable iff (!reset_n)
    !codeInValid |=> !codeOutValid && $stable(codeOut);
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("Output changed without an input word");

  c_double_flip: cover property (@(posedge clk_sys) disable iff (!reset_n)
    codeInValid && enable_q && firstOk && secondOk && firstPtr_q != secondPtr_q);
  c_single_flip: cover property (@(posedge clk_sys) disable iff (!reset_n)
    codeInValid && enable_q && firstOk && !secondOk);
  c_disabled: cover property (@(posedge clk_sys) disable iff (!reset_n)
    codeInValid && !enable_q ##1 codeOutValid);

endmodule

// ===== shared/ecc_inject_cfg.svh
`ifndef ECC_INJECT_CFG_SVH
`define ECC_INJECT_CFG_SVH

// Register offsets on the plain register port
`define ADDR_ENABLE_CONTROL  4'h0
`define ADDR_BIT_POINTERS    4'h2

// Field positions
`define ENABLE_BIT           0
`define FIRST_PTR_LSB        0
`define SECOND_PTR_LSB       8

// Reset values
`define ENABLE_CONTROL_RESET 16'h0000
`define BIT_POINTERS_RESET   16'h0000

// Code word size; pointer values at or above this flip nothing
`define CODEWORD_BITS        56
`define POINTER_LIMIT        8'h38

`endif

// ===== shared/ecc_inject_pkg.sv
package ecc_inject_pkg;
  typedef logic [55:0] codeword_type;
  typedef logic [7:0]  pointer_type;
  typedef logic [15:0] reg_word_type;
  typedef logic [3:0]  reg_addr_type;
endpackage

// ===== shared/flip_mask_if.sv
`timescale 1ns/1ps
interface flip_mask_if;
  import ecc_inject_pkg::*;
  logic         injectEnable;
  pointer_type  firstFlipPointer;
  pointer_type  secondFlipPointer;
  codeword_type flipMask;

  modport ctrl (output injectEnable, output firstFlipPointer, output secondFlipPointer, input flipMask);
  modport gen  (input injectEnable, input firstFlipPointer, input secondFlipPointer, output flipMask);
endinterface

// ===== logic/flip_mask_gen.sv
`timescale 1ns/1ps
`include "ecc_inject_cfg.svh"
module flip_mask_gen
  import ecc_inject_pkg::*;
(
  flip_mask_if.gen maskBus // Pointers in, inversion mask out
);

  // One-hot position for a pointer; out-of-range values give no bit
  function automatic codeword_type pointerToMask(input pointer_type ptr);
    codeword_type m;
    m = '0;
    if (ptr < `POINTER_LIMIT)
    begin
      m[ptr[5:0]] = 1'b1;
    end
    return m;
  endfunction

  // Equal pointers collapse to one flip rather than cancelling out
  always_comb
  begin
    if (maskBus.injectEnable)
    begin
      maskBus.flipMask = pointerToMask(maskBus.firstFlipPointer)
                       | pointerToMask(maskBus.secondFlipPointer);
    end
    else
    begin
      maskBus.flipMask = '0;
    end
  end

endmodule

// ===== bench/tb_ecc_fault_injection_control.sv
`timescale 1ns/1ps
`include "ecc_inject_cfg.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_ecc_fault_injection_control
  import ecc_inject_pkg::*;
;
  logic         clk_sys;
  logic         reset_n;
  reg_addr_type regAddr;
  reg_word_type regWrData;
  logic         regWrStrobe;
  logic         regRdStrobe;
  logic  [15:0] regRdData;
  codeword_type codeIn;
  logic         codeInValid;
  codeword_type codeOut;
  logic         codeOutValid;
  int           num_errors;
  int           checks_done;
  int           cycles;
  pointer_type  vals [4] = '{8'h00, 8'h37, 8'h38, 8'hff};
  codeword_type w;

  ecc_fault_injection_control dut (
    .clk_sys      (clk_sys),
    .reset_n      (reset_n),
    .regAddr      (regAddr),
    .regWrData    (regWrData),
    .regWrStrobe  (regWrStrobe),
    .regRdStrobe  (regRdStrobe),
    .regRdData    (regRdData),
    .codeIn       (codeIn),
    .codeInValid  (codeInValid),
    .codeOut      (codeOut),
    .codeOutValid (codeOutValid)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task give_verdict();
    if (num_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Run is about 110 cycles; generous ceiling
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      num_errors++;
      give_verdict();
    end
  end

  task wr(input reg_addr_type a, input reg_word_type d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrStrobe <= 1'b1;
    @(posedge clk_sys);
    regWrStrobe <= 1'b0;
  endtask

  task rd(input reg_addr_type a, input reg_word_type e);
    @(posedge clk_sys);
    regAddr <= a;
    regRdStrobe <= 1'b1;
    @(posedge clk_sys);
    regRdStrobe <= 1'b0;
    #1;
    `CHK("regRdData", e, regRdData)
  endtask

  // One word through the data path, expected mask m
  task send(input codeword_type d, input codeword_type m);
    @(posedge clk_sys);
    codeIn <= d;
    codeInValid <= 1'b1;
    @(posedge clk_sys);
    codeInValid <= 1'b0;
    #1;
    `CHK("codeOutValid", 1'b1, codeOutValid)
    `CHK("codeOut", d ^ m, codeOut)
  endtask

  function automatic codeword_type bitAt(input pointer_type p);
    return (p < `POINTER_LIMIT) ? (codeword_type'(1) << p) : '0;
  endfunction

  initial
  begin
    num_errors = 0;
    checks_done = 0;
    cycles = 0;
    reset_n = 1'b0;
    regAddr = '0;
    regWrData = '0;
    regWrStrobe = 1'b0;
    regRdStrobe = 1'b0;
    codeIn = '0;
    codeInValid = 1'b0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(`ADDR_ENABLE_CONTROL, 16'h0000);
    rd(`ADDR_BIT_POINTERS, 16'h0000);
    wr(`ADDR_BIT_POINTERS, 16'h0503);
    send(56'h00ff00ff00ff00, 56'h0);
    wr(`ADDR_ENABLE_CONTROL, 16'hffff);
    rd(`ADDR_ENABLE_CONTROL, 16'h0001);
    rd(4'h4, 16'h0000);
    rd(`ADDR_BIT_POINTERS, 16'h0503);
    send(56'h00ff00ff00ff00, 56'h28);
    // Every pairing of low, top, first-dead and max pointer values
    for (int i = 0; i < 4; i++)
      for (int j = 0; j < 4; j++)
      begin
        w = {28'h5a5a5a5, 28'hc3c3c3c} ^ codeword_type'(i * 4 + j);
        wr(`ADDR_BIT_POINTERS, {vals[j], vals[i]});
        send(w, bitAt(vals[i]) | bitAt(vals[j]));
      end
    // Second pointer 55 in the high byte, first pointer 0 in the low byte
    wr(`ADDR_BIT_POINTERS, 16'h3700);
    send(56'h0, 56'h80000000000001);
    wr(`ADDR_BIT_POINTERS, 16'h0038);
    send(56'h0, 56'h1);
    wr(`ADDR_ENABLE_CONTROL, 16'hfffe);
    rd(`ADDR_ENABLE_CONTROL, 16'h0000);
    send(56'hffffffffffffff, 56'h0);
    // Mid-run reset must bring every register and the output back to zero
    wr(`ADDR_BIT_POINTERS, 16'h1234);
    wr(`ADDR_ENABLE_CONTROL, 16'h0001);
    @(posedge clk_sys);
    reset_n <= 1'b0;
    @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(`ADDR_ENABLE_CONTROL, 16'h0000);
    rd(`ADDR_BIT_POINTERS, 16'h0000);
    `CHK("codeOutValid", 1'b0, codeOutValid)
    `CHK("codeOut", 56'h0, codeOut)
    give_verdict();
  end
endmodule
